// [osc_stroke_consts.vh]
/*
 * constants of the oscillation stroke generator: register offsets, field
 * positions, reset values and timing figures.
 * assumes inclusion by bare name from the generator's design file.
 */
`ifndef OSC_STROKE_CONSTS_VH
`define OSC_STROKE_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_CTRL       8'h00
`define OFF_STROKE     8'h04
`define OFF_CYCLE_TIME 8'h08
`define OFF_PULSE_CNT  8'h0c
`define OFF_SHAPE      8'h10
`define OFF_STATUS     8'h14
`define OFF_SETPOINT   8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_MODE_LSB  0
`define CTRL_MODE_MSB  2
`define CTRL_PATH_BIT  2
`define CTRL_CMD_ON    8
`define CTRL_CMD_OFF   9
`define STAT_RUN       0
`define STAT_STOPPING  1
`define STAT_REQUEST   2
`define STAT_PATH      3

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define RST_MODE       3'h0
`define RST_STROKE     16'h0064
`define RST_CYCLE_TIME 16'h03e8
`define RST_PULSE_CNT  16'h0014
`define RST_SHAPE      7'h32
`define SHAPE_MIN      7'h0a
`define SHAPE_MAX      7'h5a

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS  100
`define TICK_NS        1000000
`define PULSE_MAX_HZ   20

`endif

// [oscillation_stroke_generator.v]
/*
 * oscillation stroke generator: left/right setpoint for a web guider,
 * square-to-triangle shape, time or path timed, four start methods,
 * registers over an axi4-lite slave.
 * assumes key and pulse pins are asynchronous; autoMode comes from guider
 * logic on the same clock.
 */
`timescale 1ns/100ps
`include "osc_stroke_consts.vh"

module oscillation_stroke_generator #(
   parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
   input wire clock,               // system clock, 10 MHz
   input wire nrst,                // asynchronous reset, active low
   input wire autoMode,            // guider is in automatic mode
   input wire autoKeyPin,          // automatic key, high while pressed
   input wire oscKeyPin,           // oscillation key, high while pressed
   input wire pathPulsePin,        // external path pulse, rising edge counts
   output reg signed [16:0] setpoint, // stroke offset, positive = right
   output wire oscActive,          // oscillation running
   input wire [7:0] s_axi_awaddr,  // write address
   input wire s_axi_awvalid,       // write address valid
   output reg s_axi_awready,       // write address ready
   input wire [31:0] s_axi_wdata,  // write data
   input wire [3:0] s_axi_wstrb,   // write byte enables
   input wire s_axi_wvalid,        // write data valid
   output reg s_axi_wready,        // write data ready
   output reg [1:0] s_axi_bresp,   // write response
   output reg s_axi_bvalid,        // write response valid
   input wire s_axi_bready,        // write response ready
   input wire [7:0] s_axi_araddr,  // read address
   input wire s_axi_arvalid,       // read address valid
   output reg s_axi_arready,       // read address ready
   output reg [31:0] s_axi_rdata,  // read data
   output reg [1:0] s_axi_rresp,   // read response
   output reg s_axi_rvalid,        // read data valid
   input wire s_axi_rready         // read data ready
);

   localparam DIV_IDLE = 2'd0;
   localparam DIV_PHASE = 2'd1;
   localparam DIV_SHAPE = 2'd2;

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16 = old;
         if (strb[0]) merge16[7:0] = data[7:0];
         if (strb[1]) merge16[15:8] = data[15:8];
      end
   endfunction

   function [6:0] clampShape;
      input [7:0] v;
      begin
         if (v < {1'b0, `SHAPE_MIN}) clampShape = `SHAPE_MIN;
         else if (v > {1'b0, `SHAPE_MAX}) clampShape = `SHAPE_MAX;
         else clampShape = v[6:0];
      end
   endfunction

   // ----------------------------------------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------------------------------------
   reg [2:0] syncA_reg, syncB_reg, last_reg;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         syncA_reg <= 3'h0;
         syncB_reg <= 3'h0;
         last_reg <= 3'h0;
      end else begin
         syncA_reg <= {pathPulsePin, oscKeyPin, autoKeyPin};
         syncB_reg <= syncA_reg;
         last_reg <= syncB_reg;
      end
   end
   wire autoKeyEdge = syncB_reg[0] & ~last_reg[0];
   wire oscKeyEdge = syncB_reg[1] & ~last_reg[1];
   // single edge per pulse; a 20 Hz source gives 5e5 cycles between edges
   wire pathEdge = syncB_reg[2] & ~last_reg[2];

   // ----------------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------------
   reg [31:0] tickCnt_reg;
   wire msTick = (tickCnt_reg == TICK_CYCLES - 1);
   always @(posedge clock or negedge nrst) begin
      if (!nrst) tickCnt_reg <= 32'h0;
      else if (msTick) tickCnt_reg <= 32'h0;
      else tickCnt_reg <= tickCnt_reg + 32'h1;
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg [2:0] startMode_reg;
   reg [15:0] stroke_reg, cycleTime_reg, pulseCnt_reg;
   reg [6:0] shape_reg;
   reg running_reg, stopping_reg, request_reg, autoModeDly_reg;
   reg awHeld_reg, wHeld_reg;
   reg [7:0] awAddr_reg;
   reg [31:0] wData_reg;
   reg [3:0] wStrb_reg;

   wire pathMode = startMode_reg[`CTRL_PATH_BIT];
   wire [1:0] method = startMode_reg[1:0];
   wire doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
   wire ctrlWr = doWrite & (awAddr_reg == `OFF_CTRL);
   wire cmdOn = ctrlWr & wStrb_reg[1] & wData_reg[`CTRL_CMD_ON];
   wire cmdOff = ctrlWr & wStrb_reg[1] & wData_reg[`CTRL_CMD_OFF];

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h0;
         wData_reg <= 32'h0;
         wStrb_reg <= 4'h0;
         startMode_reg <= `RST_MODE;
         stroke_reg <= `RST_STROKE;
         cycleTime_reg <= `RST_CYCLE_TIME;
         pulseCnt_reg <= `RST_PULSE_CNT;
         shape_reg <= `RST_SHAPE;
      end else begin
         s_axi_awready <= ~awHeld_reg & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~wHeld_reg & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (s_axi_bvalid & s_axi_bready) s_axi_bvalid <= 1'b0;
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (awAddr_reg)
               `OFF_CTRL: begin
                  if (wStrb_reg[0]) startMode_reg <= wData_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
               end
               `OFF_STROKE: stroke_reg <= merge16(stroke_reg, wData_reg, wStrb_reg);
               `OFF_CYCLE_TIME: cycleTime_reg <= merge16(cycleTime_reg, wData_reg, wStrb_reg);
               `OFF_PULSE_CNT: pulseCnt_reg <= merge16(pulseCnt_reg, wData_reg, wStrb_reg);
               `OFF_SHAPE: begin
                  if (wStrb_reg[0]) shape_reg <= clampShape(wData_reg[7:0]);
               end
               `OFF_STATUS, `OFF_SETPOINT: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end
      end
   end

   // read channel: one cycle from address taken to data valid
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_rvalid & s_axi_rready) s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `OFF_CTRL: s_axi_rdata <= {29'h0, startMode_reg};
               `OFF_STROKE: s_axi_rdata <= {16'h0, stroke_reg};
               `OFF_CYCLE_TIME: s_axi_rdata <= {16'h0, cycleTime_reg};
               `OFF_PULSE_CNT: s_axi_rdata <= {16'h0, pulseCnt_reg};
               `OFF_SHAPE: s_axi_rdata <= {25'h0, shape_reg};
               `OFF_STATUS: s_axi_rdata <= {28'h0, pathMode, request_reg, stopping_reg, running_reg};
               `OFF_SETPOINT: s_axi_rdata <= {{15{setpoint[16]}}, setpoint};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // start method
   // ----------------------------------------------------------------------
   // autoModeDly keeps the key press that enters automatic mode from toggling
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         request_reg <= 1'b0;
         autoModeDly_reg <= 1'b0;
      end else begin
         autoModeDly_reg <= autoMode;
         case (method)
            2'd0: begin
               if (cmdOn) request_reg <= 1'b1;
               else if (cmdOff) request_reg <= 1'b0;
               else if (oscKeyEdge) request_reg <= ~request_reg;
            end
            2'd1: begin
               if (!autoMode) request_reg <= 1'b0;
               else if (autoKeyEdge & autoModeDly_reg) request_reg <= ~request_reg;
            end
            2'd2: request_reg <= 1'b0;
            2'd3: request_reg <= autoMode;
            default: request_reg <= 1'b0;
         endcase
      end
   end
   wire want = request_reg & autoMode;

   // ----------------------------------------------------------------------
   // position within the period
   // ----------------------------------------------------------------------
   reg [15:0] pos_reg;
   wire [15:0] period = pathMode ? pulseCnt_reg : cycleTime_reg;
   wire [15:0] periodSafe = (period == 16'h0) ? 16'h1 : period;
   wire step = running_reg & (pathMode ? pathEdge : msTick);
   wire [15:0] posInc = pos_reg + 16'h1;
   wire [15:0] newPos = (posInc >= periodSafe) ? 16'h0 : posInc;
   wire [16:0] twiceNew = {newPos, 1'b0};
   wire [16:0] twiceOld = {pos_reg, 1'b0};
   wire crossing = (newPos == 16'h0) | (twiceNew >= {1'b0, periodSafe} & twiceOld < {1'b0, periodSafe});
   assign oscActive = running_reg;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         running_reg <= 1'b0;
         stopping_reg <= 1'b0;
         pos_reg <= 16'h0;
      end else if (!running_reg) begin
         stopping_reg <= 1'b0;
         pos_reg <= 16'h0;
         if (want) running_reg <= 1'b1;
      end else begin
         if (want) stopping_reg <= 1'b0;
         else stopping_reg <= 1'b1;
         // a stop only completes when the period keeps advancing
         if (step) begin
            if ((stopping_reg | ~want) & crossing) begin
               running_reg <= 1'b0;
               stopping_reg <= 1'b0;
               pos_reg <= 16'h0;
            end else begin
               pos_reg <= newPos;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // shared divider: phase = pos/period, then shaped = tri*90/shape
   // ----------------------------------------------------------------------
   reg [1:0] divState_reg;
   reg [5:0] divCnt_reg;
   reg [31:0] divNum_reg, divQuo_reg;
   reg [16:0] divRem_reg;
   reg [15:0] divDen_reg;
   reg half_reg, dirty_reg;
   wire [16:0] remShift = {divRem_reg[15:0], divNum_reg[31]};
   wire remGe = remShift >= {1'b0, divDen_reg};
   wire [16:0] remNext = remGe ? (remShift - {1'b0, divDen_reg}) : remShift;
   wire [31:0] quoNext = {divQuo_reg[30:0], remGe};
   // triangle magnitude over each half period, rising then falling
   wire [15:0] triMag = quoNext[14] ? ~{quoNext[13:0], 2'b00} : {quoNext[13:0], 2'b00};
   // tri * 90 as shifted sums: 64 + 16 + 8 + 2
   wire [31:0] shapeNum = {10'h0, triMag, 6'h0} + {12'h0, triMag, 4'h0} + {13'h0, triMag, 3'h0} + {15'h0, triMag, 1'b0};
   wire [15:0] shapedMag = (quoNext[31:16] != 16'h0) ? 16'hffff : quoNext[15:0];
   wire [31:0] peak = stroke_reg * shapedMag;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         divState_reg <= DIV_IDLE;
         divCnt_reg <= 6'h0;
         divNum_reg <= 32'h0;
         divQuo_reg <= 32'h0;
         divRem_reg <= 17'h0;
         divDen_reg <= 16'h1;
         half_reg <= 1'b0;
         dirty_reg <= 1'b1;
         setpoint <= 17'h0;
      end else begin
         if (step | ~running_reg) dirty_reg <= 1'b1;
         case (divState_reg)
            DIV_IDLE: begin
               if (!running_reg) begin
                  setpoint <= 17'h0;
               end else if (dirty_reg) begin
                  dirty_reg <= 1'b0;
                  divNum_reg <= {pos_reg, 16'h0};
                  divDen_reg <= periodSafe;
                  divQuo_reg <= 32'h0;
                  divRem_reg <= 17'h0;
                  divCnt_reg <= 6'h0;
                  divState_reg <= DIV_PHASE;
               end
            end
            DIV_PHASE, DIV_SHAPE: begin
               divRem_reg <= remNext;
               divQuo_reg <= quoNext;
               divNum_reg <= {divNum_reg[30:0], 1'b0};
               divCnt_reg <= divCnt_reg + 6'h1;
               if (divCnt_reg == 6'd31) begin
                  divCnt_reg <= 6'h0;
                  divRem_reg <= 17'h0;
                  divQuo_reg <= 32'h0;
                  if (divState_reg == DIV_PHASE) begin
                     half_reg <= quoNext[15];
                     // gain 90/shape: 10 saturates early (square), 90 stays linear
                     divNum_reg <= shapeNum;
                     divDen_reg <= {9'h0, shape_reg};
                     divState_reg <= DIV_SHAPE;
                  end else begin
                     divState_reg <= DIV_IDLE;
                     if (running_reg) begin
                        // symmetric peak: same magnitude to both sides
                        if (half_reg) setpoint <= -$signed({1'b0, peak[31:16]});
                        else setpoint <= $signed({1'b0, peak[31:16]});
                     end
                  end
               end
            end
            default: divState_reg <= DIV_IDLE;
         endcase
         // a stopped generator sits at centre at once; a stale divider result must not linger
         if (!running_reg) begin
            divState_reg <= DIV_IDLE;
            setpoint <= 17'h0;
         end
      end
   end

endmodule // oscillation_stroke_generator

// [path_pulse_source.sv]
/* path pulse source standing in for the external web-length pulse generator.
   assumes one bench clock; the bench switches pulsing on and off. */
`timescale 1ns/100ps
module path_pulse_source #(
   parameter int PERIOD = 520
) (
   input wire logic clock, // bench clock
   input wire logic nrst, // reset, active low
   input wire logic enable, // pulsing allowed
   output logic pulse // path pulse line
);
   int count;
   // period kept at or above the scaled 20 Hz floor; line rests low while paused
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count <= 0;
         pulse <= 1'b0;
      end else if (!enable) begin
         pulse <= 1'b0;
      end else begin
         count <= (count == PERIOD - 1) ? 0 : count + 1;
         pulse <= (count < PERIOD / 2);
      end
   end
endmodule // path_pulse_source

// [osc_stroke_checker.sv]
/* port assertions for the oscillation stroke generator.
   assumes binding to the generator; mode and stroke are mirrored from bus writes. */
`timescale 1ns/100ps
`include "osc_stroke_consts.vh"
module osc_stroke_checker (
   input wire clock, // system clock
   input wire nrst, // reset, active low
   input wire autoMode, // automatic mode
   input wire signed [16:0] setpoint, // stroke setpoint
   input wire oscActive, // running
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   input wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire s_axi_wvalid, // write data valid
   input wire s_axi_wready, // write data ready
   input wire [1:0] s_axi_bresp, // write response
   input wire s_axi_bvalid, // write response valid
   input wire s_axi_bready // write response ready
);
   reg [7:0] wrAddr_reg;
   reg [31:0] wrData_reg;
   reg [2:0] mode_reg;
   reg [15:0] stroke_reg;
   // mirror lags the design by a cycle, so the bench only rewrites stroke while idle
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wrAddr_reg <= 8'h00;
         wrData_reg <= 32'h0;
         mode_reg <= `RST_MODE;
         stroke_reg <= `RST_STROKE;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wrAddr_reg <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wrData_reg <= s_axi_wdata;
         if (s_axi_bvalid && s_axi_bready && wrAddr_reg == `OFF_CTRL) mode_reg <= wrData_reg[2:0];
         if (s_axi_bvalid && s_axi_bready && wrAddr_reg == `OFF_STROKE) stroke_reg <= wrData_reg[15:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_idle_zero: assert property (!oscActive [*3] |-> setpoint == 17'h0)
      else $error("setpoint not zero while idle");
   a_start_centre: assert property (!oscActive [*3] ##1 oscActive |-> setpoint == 17'h0)
      else $error("oscillation did not start at centre");
   a_stop_centre: assert property ($fell(oscActive) |-> ##[0:2] setpoint == 17'h0)
      else $error("stop did not end at centre");
   a_stroke_bound: assert property (oscActive |-> setpoint <= $signed({1'b0, stroke_reg})
      && setpoint >= -$signed({1'b0, stroke_reg})) else $error("setpoint beyond stroke");
   a_never_mode: assert property (mode_reg[1:0] == 2'h2 && !oscActive |=> !oscActive)
      else $error("oscillation started in disabled mode");
   a_always_mode: assert property (mode_reg[1:0] == 2'h3 && autoMode && !oscActive
      |-> ##[1:8] oscActive) else $error("oscillation not started with automatic mode");
   a_needs_auto: assert property (!autoMode && !oscActive |=> !oscActive)
      else $error("oscillation started outside automatic mode");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   c_start: cover property ($rose(oscActive));
   c_stop: cover property ($fell(oscActive));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // osc_stroke_checker

// [tb_top.sv]
/* self-checking bench for the oscillation stroke generator.
   assumes the generator, its constants header, the checker and the pulse source. */
`timescale 1ns/100ps
`include "osc_stroke_consts.vh"
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin nErrors++; \
   $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
   localparam int TICK = 10;
   localparam int PP = 520;
   logic clock = 1'b0, nrst = 1'b0, autoMode = 1'b0, autoKeyPin = 1'b0, oscKeyPin = 1'b0, pulseEn = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, seed = 32'h0000c334;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire pathPulsePin, oscActive, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire signed [16:0] setpoint;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic [33:0] expQ[$];
   logic [33:0] note;
   int nErrors = 0, nChecks = 0, strokeVal, v;
   logic [31:0] v_tab [8] = '{32'(`RST_MODE), 32'(`RST_STROKE), 32'(`RST_CYCLE_TIME), 32'(`RST_PULSE_CNT),
      32'(`RST_SHAPE), 32'h0, 32'h0, 32'h0};
   oscillation_stroke_generator #(.TICK_CYCLES(TICK)) dut (.clock(clock), .nrst(nrst), .autoMode(autoMode),
      .autoKeyPin(autoKeyPin), .oscKeyPin(oscKeyPin), .pathPulsePin(pathPulsePin), .setpoint(setpoint),
      .oscActive(oscActive), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   path_pulse_source #(.PERIOD(PP)) source (.clock(clock), .nrst(nrst), .enable(pulseEn), .pulse(pathPulsePin));
   always #50 clock = ~clock;
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   // ------------------------------------------------------------
   // bus master, key presses and waveform measurement
   // ------------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'b0;
      expQ.push_back({er, w ? 32'h0 : d});
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      while (!done) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid || s_axi_rvalid) begin
            done = 1'b1;
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
         end
      end
      // one edge between transfers so a following call never re-drives a released strobe in this step
      @(posedge clock);
   endtask
   task automatic press(input logic auto);
      if (auto) autoKeyPin <= 1'b1;
      else oscKeyPin <= 1'b1;
      repeat (4) @(posedge clock);
      autoKeyPin <= 1'b0;
      oscKeyPin <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   // one period from entry into the negative half to the next, with its peaks
   task automatic measure(input int expCycles);
      int t, hi, lo;
      logic seen;
      hi = 0;
      lo = 0;
      seen = 1'b0;
      t = 0;
      while (setpoint < 0) @(posedge clock);
      while (setpoint >= 0) @(posedge clock);
      while (!(seen && setpoint < 0)) begin
         @(posedge clock);
         t++;
         if (setpoint >= 0) seen = 1'b1;
         if (setpoint > hi) hi = setpoint;
         if (setpoint < lo) lo = setpoint;
      end
      `CHK(t >= expCycles - 1 && t <= expCycles + 1, 1'b1)
      `CHK(hi >= strokeVal - 1 && hi <= strokeVal && -lo >= strokeVal - 1 && -lo <= strokeVal, 1'b1)
   endtask
   always @(posedge clock) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         note = expQ.pop_front();
         if (s_axi_bvalid) `CHK({s_axi_bresp, 32'h0}, note)
         else `CHK({s_axi_rresp, s_axi_rdata}, note)
      end
   end
   task automatic tallyAndFinish;
      $display("checks %0d, errors %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      bus(1, `OFF_STATUS, 32'hf, 2'h0);
      foreach (v_tab[i]) bus(0, 8'(i * 4), v_tab[i], (i == 7) ? 2'h2 : 2'h0);
      bus(1, 8'h1c, 32'h5, 2'h2);
      for (int i = 0; i < 3; i++) begin
         seed = xorshift(seed);
         v = (i == 0) ? 5 : (i == 1) ? 95 : 10 + seed % 81;
         bus(1, `OFF_SHAPE, v, 2'h0);
         bus(0, `OFF_SHAPE, (v < 10) ? 10 : (v > 90) ? 90 : v, 2'h0);
      end
      seed = xorshift(seed);
      strokeVal = seed[15:0] | 16'h1;
      bus(1, `OFF_STROKE, strokeVal, 2'h0);
      bus(0, `OFF_STROKE, strokeVal, 2'h0);
      bus(1, `OFF_SHAPE, 32'ha, 2'h0);
      // 65 ms: a whole number of 65-cycle setpoint refreshes, so the seen sign change cannot beat with the fast tick
      bus(1, `OFF_CYCLE_TIME, 32'h41, 2'h0);
      bus(1, `OFF_PULSE_CNT, 32'h4, 2'h0);
      $display("register test done");
      for (int m = 0; m < 8; m++) begin
         autoMode <= 1'b0;
         @(posedge clock);
         bus(1, `OFF_CTRL, m, 2'h0);
         autoMode <= (m % 4 != 3);
         repeat (4) @(posedge clock);
         case (m % 4)
            0: begin
               press(1);
               bus(0, `OFF_STATUS, {28'h0, m[2], 3'b000}, 2'h0);
               if (m == 0) bus(1, `OFF_CTRL, 32'h100 | m, 2'h0);
               else press(0);
            end
            1: press(1);
            2: begin
               press(0);
               press(1);
               bus(1, `OFF_CTRL, 32'h100 | m, 2'h0);
            end
            default: autoMode <= 1'b1;
         endcase
         repeat (8) @(posedge clock);
         bus(0, `OFF_STATUS, {28'h0, m[2], (m % 4 == 2) ? 3'b000 : 3'b101}, 2'h0);
         if (m % 4 != 2) begin
            measure(m[2] ? 4 * PP : 65 * TICK);
            while (setpoint <= 0) @(posedge clock);
            case (m % 4)
               0: if (m == 0) bus(1, `OFF_CTRL, 32'h200 | m, 2'h0);
                  else press(0);
               1: press(1);
               default: autoMode <= 1'b0;
            endcase
            if (m[2]) begin
               pulseEn <= 1'b0;
               repeat (1200) @(posedge clock);
            end
            bus(0, `OFF_STATUS, {28'h0, m[2], 3'b011}, 2'h0);
            pulseEn <= 1'b1;
            while (oscActive) @(posedge clock);
            repeat (2) @(posedge clock);
         end
         bus(0, `OFF_SETPOINT, 32'h0, 2'h0);
         $display("mode %0d done", m);
      end
      tallyAndFinish;
   end
   initial begin
      repeat (100000) @(posedge clock);
      nErrors++;
      $display("ERROR at %0t: watchdog expired", $time);
      tallyAndFinish;
   end
endmodule // tb_top
bind oscillation_stroke_generator osc_stroke_checker chk (.clock(clock), .nrst(nrst), .autoMode(autoMode),
   .setpoint(setpoint), .oscActive(oscActive), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready));
